// file: logic/p1io_port.sv
`timescale 1ns/100ps
// Function
// - direction bit 1 drives the pin, 0 makes it an input
// - pull-up on only for input with latch bit 1
// - normal data read returns the eight synchronised pin levels
// - read-modify-write view returns stored latch contents
// - function bit 0 on an output drives the latch value
// - bits 3 to 5 always drive latch value as outputs
// - bit 2 function mode drives serial clock OR latch
// - bits 1 and 0 function mode drive serial data OR latch
// - bit 7 function mode drives selected pwm or buzzer XOR latch
// - bit 7 source: route selects pwm, else buzzer if enabled, else none
// - bit 6 function mode drives pwm AND comparator, XOR latch
// - comparator control set removes comparator gating on bit 6
// - pin 7 feeds irq one with level or edge detection
// - pins 6 and 5 feed irq two and three, edge detection
// - irq four takes pin 3 or pin 4, edge detection
// - flag-setting change on selected pin 6 or 5 counts timer 0
// - timer 0 low capture strobe from selected source, level repeats
// - timer 0 high capture strobe from selected source, level repeats
// - flag-setting change on selected pin 4 or 3 counts timer 1
// - flag and enable of irq zero, one, two, four release hold
// - in hold, irq two edge toward entry level sets no flag
// - pin 7 releases hold only in level detection
// - flags stay set until software clears them
// - edge control: rising and falling enables, none, either, both
// - irq one control: polarity and level bits select four conditions
`include "p1io_defines.svh"
module p1io_port
  import p1io_pkg::*;
(
  input logic hclk,
  input logic hresetn,
  input logic hsel,
  input logic [31:0] haddr,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic [2:0] hsize,
  input logic [31:0] hwdata,
  input logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input logic [7:0] pin_in,
  input logic irq_zero_pin,
  input logic fast_pwm_second_output,
  input logic buzzer_in,
  input logic comparator_in,
  input logic serial_clk_in,
  input logic serial_data_in,
  input logic hold_mode,
  output p1io_pins_t pins,
  output p1io_tmr_t tmr,
  output logic [4:0] irq_req,
  output logic hold_release
);

  // =============================================================
  // helpers
  function automatic logic edge_hit(input logic cur, input logic prv,
                                    input logic rise, input logic fall);
    edge_hit = (rise & cur & ~prv) | (fall & ~cur & prv);
  endfunction

  function automatic logic lvl_hit(input logic cur, input logic prv,
                                   input logic pol, input logic lvl);
    if (lvl) begin
      lvl_hit = (cur == pol);
    end else begin
      lvl_hit = pol ? (cur & ~prv) : (~cur & prv);
    end
  endfunction

  // =============================================================
  // pin synchronisers
  logic [7:0] sync1_q, pins_q, prev_q;
  logic p70_s1_q, p70_q, p70_prev_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_q <= 8'h00;
      pins_q <= 8'h00;
      prev_q <= 8'h00;
      p70_s1_q <= 1'h0;
      p70_q <= 1'h0;
      p70_prev_q <= 1'h0;
    end else begin
      sync1_q <= pin_in;
      pins_q <= sync1_q;
      prev_q <= pins_q;
      p70_s1_q <= irq_zero_pin;
      p70_q <= p70_s1_q;
      p70_prev_q <= p70_q;
    end
  end

  // =============================================================
  // bus slave: zero wait states, always OKAY
  logic a_wr_q;
  logic [15:0] a_idx_q;
  logic take;
  logic [15:0] idx;
  logic idx_ok;

  assign take = hsel & htrans[1] & hready;
  assign idx = haddr[17:2];
  assign idx_ok = (haddr[31:18] == 14'h0000) & (haddr[1:0] == 2'h0);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_wr_q <= 1'h0;
      a_idx_q <= 16'h0000;
    end else begin
      a_wr_q <= take & hwrite & idx_ok;
      a_idx_q <= idx_ok ? idx : 16'h0000;
    end
  end

  // =============================================================
  // registers
  logic [7:0] latch_q, dir_q, fsel_q, xctl_q, ext_irq_four_five_ctrl_q, ext_irq_four_five_pin_select_q, i01_q, i23_q, isl_q;
  logic [7:0] latch_d, dir_d, fsel_d, xctl_d, ext_irq_four_five_ctrl_d, ext_irq_four_five_pin_select_d, i01_d, i23_d, isl_d;
  logic [7:0] wdat;
  logic ev0, ev1, ev2, ev3, ev4, raw2, src4, prv4;

  assign wdat = hwdata[7:0];

  always_comb begin
    latch_d = latch_q;
    dir_d = dir_q;
    fsel_d = fsel_q;
    xctl_d = xctl_q;
    ext_irq_four_five_ctrl_d = ext_irq_four_five_ctrl_q;
    ext_irq_four_five_pin_select_d = ext_irq_four_five_pin_select_q;
    i01_d = i01_q;
    i23_d = i23_q;
    isl_d = isl_q;
    if (a_wr_q) begin
      if (a_idx_q == `P1IO_IDX_LATCH || a_idx_q == `P1IO_IDX_RMW) begin
        latch_d = wdat;
      end else if (a_idx_q == `P1IO_IDX_DIR) begin
        dir_d = wdat;
      end else if (a_idx_q == `P1IO_IDX_FSEL) begin
        fsel_d = wdat;
      end else if (a_idx_q == `P1IO_IDX_XCTL) begin
        xctl_d = wdat;
      end else if (a_idx_q == `P1IO_IDX_EXT_IRQ_FOUR_FIVE_CTRL) begin
        ext_irq_four_five_ctrl_d = {4'h0, wdat[3:0]};
      end else if (a_idx_q == `P1IO_IDX_EXT_IRQ_FOUR_FIVE_PIN_SELECT) begin
        ext_irq_four_five_pin_select_d = {4'h0, wdat[3:0]};
      end else if (a_idx_q == `P1IO_IDX_EXT_IRQ_ZERO_ONE_CTRL) begin
        i01_d = wdat;
      end else if (a_idx_q == `P1IO_IDX_EXT_IRQ_TWO_THREE_CTRL) begin
        i23_d = wdat;
      end else if (a_idx_q == `P1IO_IDX_ISL) begin
        isl_d = wdat;
      end
    end
    // set beats a simultaneous software clear
    i01_d[`P1IO_IF] = i01_d[`P1IO_IF] | ev0;
    i01_d[`P1IO_HI+`P1IO_IF] = i01_d[`P1IO_HI+`P1IO_IF] | ev1;
    i23_d[`P1IO_IF] = i23_d[`P1IO_IF] | ev2;
    i23_d[`P1IO_HI+`P1IO_IF] = i23_d[`P1IO_HI+`P1IO_IF] | ev3;
    ext_irq_four_five_ctrl_d[`P1IO_IF] = ext_irq_four_five_ctrl_d[`P1IO_IF] | ev4;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      latch_q <= `P1IO_RST8;
      dir_q <= `P1IO_RST8;
      fsel_q <= `P1IO_RST8;
      xctl_q <= `P1IO_RST8;
      ext_irq_four_five_ctrl_q <= `P1IO_RST8;
      ext_irq_four_five_pin_select_q <= `P1IO_RST8;
      i01_q <= `P1IO_RST8;
      i23_q <= `P1IO_RST8;
      isl_q <= `P1IO_RST8;
    end else begin
      latch_q <= latch_d;
      dir_q <= dir_d;
      fsel_q <= fsel_d;
      xctl_q <= xctl_d;
      ext_irq_four_five_ctrl_q <= ext_irq_four_five_ctrl_d;
      ext_irq_four_five_pin_select_q <= ext_irq_four_five_pin_select_d;
      i01_q <= i01_d;
      i23_q <= i23_d;
      isl_q <= isl_d;
    end
  end

  // =============================================================
  // read data: sampled at the address phase, after any write in flight
  logic [7:0] rd8;

  always_comb begin
    rd8 = 8'h00;
    if (!(take & ~hwrite & idx_ok)) begin
      rd8 = 8'h00;
    end else if (idx == `P1IO_IDX_LATCH) begin
      rd8 = pins_q;
    end else if (idx == `P1IO_IDX_RMW) begin
      rd8 = latch_d;
    end else if (idx == `P1IO_IDX_DIR) begin
      rd8 = dir_d;
    end else if (idx == `P1IO_IDX_FSEL) begin
      rd8 = fsel_d;
    end else if (idx == `P1IO_IDX_TST) begin
      rd8 = `P1IO_TST_RD;
    end else if (idx == `P1IO_IDX_XCTL) begin
      rd8 = xctl_d;
    end else if (idx == `P1IO_IDX_EXT_IRQ_FOUR_FIVE_CTRL) begin
      rd8 = ext_irq_four_five_ctrl_d;
    end else if (idx == `P1IO_IDX_EXT_IRQ_FOUR_FIVE_PIN_SELECT) begin
      rd8 = ext_irq_four_five_pin_select_d;
    end else if (idx == `P1IO_IDX_EXT_IRQ_ZERO_ONE_CTRL) begin
      rd8 = i01_d;
    end else if (idx == `P1IO_IDX_EXT_IRQ_TWO_THREE_CTRL) begin
      rd8 = i23_d;
    end else if (idx == `P1IO_IDX_ISL) begin
      rd8 = isl_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'h1;
      hresp <= 1'h0;
    end else begin
      hrdata <= {24'h000000, rd8};
      hreadyout <= 1'h1;
      hresp <= 1'h0;
    end
  end

  // =============================================================
  // interrupt detection
  logic hold_prev_q, hold_lvl_q;

  // entry level of pin 6 remembered for the hold window
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hold_prev_q <= 1'h0;
      hold_lvl_q <= 1'h0;
    end else begin
      hold_prev_q <= hold_mode;
      if (hold_mode & ~hold_prev_q) begin
        hold_lvl_q <= pins_q[6];
      end
    end
  end

  assign ev0 = lvl_hit(p70_q, p70_prev_q, i01_q[`P1IO_CA], i01_q[`P1IO_CB]);
  assign ev1 = lvl_hit(pins_q[7], prev_q[7], i01_q[`P1IO_HI+`P1IO_CA], i01_q[`P1IO_HI+`P1IO_CB]);
  assign raw2 = edge_hit(pins_q[6], prev_q[6], i23_q[`P1IO_CA], i23_q[`P1IO_CB]);
  // an edge that only returns the pin to its hold-entry level is dropped
  assign ev2 = raw2 & ~(hold_mode & hold_prev_q & (pins_q[6] == hold_lvl_q));
  assign ev3 = edge_hit(pins_q[5], prev_q[5], i23_q[`P1IO_HI+`P1IO_CA], i23_q[`P1IO_HI+`P1IO_CB]);
  assign src4 = ext_irq_four_five_pin_select_q[`P1IO_I4_PSEL_LO] ? pins_q[4] : pins_q[3];
  assign prv4 = ext_irq_four_five_pin_select_q[`P1IO_I4_PSEL_LO] ? prev_q[4] : prev_q[3];
  // inhibited pin codes give no source at all
  assign ev4 = ~ext_irq_four_five_pin_select_q[`P1IO_I4_PSEL_HI] & edge_hit(src4, prv4, ext_irq_four_five_ctrl_q[`P1IO_CA], ext_irq_four_five_ctrl_q[`P1IO_CB]);

  // =============================================================
  // timer strobes, hold release, requests
  logic [1:0] i4fn;
  logic [4:0] pend;

  assign i4fn = ext_irq_four_five_pin_select_q[1:0];
  assign pend = {ext_irq_four_five_ctrl_q[`P1IO_IF] & ext_irq_four_five_ctrl_q[`P1IO_IE],
                 i23_q[`P1IO_HI+`P1IO_IF] & i23_q[`P1IO_HI+`P1IO_IE],
                 i23_q[`P1IO_IF] & i23_q[`P1IO_IE],
                 i01_q[`P1IO_HI+`P1IO_IF] & i01_q[`P1IO_HI+`P1IO_IE],
                 i01_q[`P1IO_IF] & i01_q[`P1IO_IE]};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tmr <= '0;
      irq_req <= 5'h00;
      hold_release <= 1'h0;
    end else begin
      tmr.t0_cnt <= xctl_q[`P1IO_XCTL_T0EN] & (xctl_q[`P1IO_XCTL_T0SRC] ? ev3 : ev2);
      tmr.t0l_cap <= (isl_q[`P1IO_ISL_CAPL] ? ev2 : ev0) | ((i4fn == `P1IO_I4FN_CAPL) & ev4);
      tmr.t0h_cap <= (isl_q[`P1IO_ISL_CAPH] ? ev3 : ev1) | ((i4fn == `P1IO_I4FN_CAPH) & ev4);
      tmr.t1_cnt <= (i4fn == `P1IO_I4FN_T1) & ev4;
      irq_req <= pend;
      // irq three never wakes; pin 7 only in level mode
      hold_release <= pend[0] | pend[2] | pend[4] |
                      (pend[1] & i01_q[`P1IO_HI+`P1IO_CB]);
    end
  end

  // =============================================================
  // pin drive
  logic [7:0] fn_sig, drv;
  logic p7_src;

  assign p7_src = xctl_q[`P1IO_XCTL_ROUTE] ? fast_pwm_second_output
                : (isl_q[`P1IO_ISL_BUZ] & buzzer_in);
  assign fn_sig[0] = serial_data_in | latch_q[0];
  assign fn_sig[1] = serial_data_in | latch_q[1];
  assign fn_sig[2] = serial_clk_in | latch_q[2];
  assign fn_sig[5:3] = latch_q[5:3];
  assign fn_sig[6] = (fast_pwm_second_output & (xctl_q[`P1IO_XCTL_CMP] | comparator_in))
                   ^ latch_q[6];
  assign fn_sig[7] = p7_src ^ latch_q[7];
  assign drv = (fsel_q & fn_sig) | (~fsel_q & latch_q);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pins <= '0;
    end else begin
      pins.out <= drv & dir_q;
      pins.oe <= dir_q;
      pins.pu <= ~dir_q & latch_q;
    end
  end

  // =============================================================
  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_dir_oe: assert property (pins.oe == $past(dir_q)) else $error("oe differs from direction");
  a_pull_up: assert property (##1 pins.pu == $past(~dir_q & latch_q)) else $error("pull-up wrong");
  a_plain_bit: assert property (dir_q[4] |=> pins.out[4] == $past(latch_q[4]))
    else $error("bit 4 not latch");
  a_sclk_force: assert property (dir_q[2] & fsel_q[2] & latch_q[2] |=> pins.out[2])
    else $error("bit 2 not forced high");
  a_p7_pwm: assert property (dir_q[7] & fsel_q[7] & xctl_q[1] & ~latch_q[7]
    |=> pins.out[7] == $past(fast_pwm_second_output)) else $error("bit 7 pwm wrong");
  a_cmp_off: assert property (dir_q[6] & fsel_q[6] & xctl_q[5] & ~latch_q[6]
    |=> pins.out[6] == $past(fast_pwm_second_output)) else $error("comparator gates");
  a_irq1_flag: assert property (ev1 |=> i01_q[5]) else $error("irq one flag lost");
  a_flag_sticky: assert property (i23_q[1] & ~(a_wr_q & a_idx_q == `P1IO_IDX_EXT_IRQ_TWO_THREE_CTRL) |=> i23_q[1])
    else $error("flag cleared by hardware");
  a_hold_wake: assert property (i01_q[1] & i01_q[0] |=> hold_release) else $error("no hold release");
  a_p7_edge_nowake: assert property (pend == 5'h02 & ~i01_q[6] |=> !hold_release)
    else $error("edge pin 7 released hold");
  a_t1_count: assert property (ev4 & i4fn == 2'h1 |=> tmr.t1_cnt) else $error("timer 1 count missing");
  a_sync_delay: assert property ($rose(pin_in[0]) ##2 $stable(pin_in[0]) |-> pins_q[0])
    else $error("pin sync depth wrong");

  c_irq1: cover property (ev1 ##1 i01_q[5]);
  c_wake: cover property (hold_mode ##[1:20] hold_release);
  c_capl: cover property (tmr.t0l_cap);
  c_rmw_rd: cover property (take & ~hwrite & idx == `P1IO_IDX_RMW);

endmodule // p1io_port

// file: logic/p1io_defines.svh
`ifndef P1IO_DEFINES_SVH
`define P1IO_DEFINES_SVH
// =============================================================
// register indices (byte address = 4 * index)
`define P1IO_IDX_LATCH 16'hFE44
`define P1IO_IDX_DIR 16'hFE45
`define P1IO_IDX_FSEL 16'hFE46
`define P1IO_IDX_TST 16'hFE47
`define P1IO_IDX_RMW 16'hFE48
`define P1IO_IDX_XCTL 16'hFE49
`define P1IO_IDX_EXT_IRQ_FOUR_FIVE_CTRL 16'hFE4A
`define P1IO_IDX_EXT_IRQ_FOUR_FIVE_PIN_SELECT 16'hFE4B
`define P1IO_IDX_EXT_IRQ_ZERO_ONE_CTRL 16'hFE5D
`define P1IO_IDX_EXT_IRQ_TWO_THREE_CTRL 16'hFE5E
`define P1IO_IDX_ISL 16'hFE5F
// =============================================================
// reset and fixed values
`define P1IO_RST8 8'h00
`define P1IO_TST_RD 8'h5E
// =============================================================
// field positions: per-interrupt nibble, low or high half
`define P1IO_IE 0
`define P1IO_IF 1
`define P1IO_CB 2
`define P1IO_CA 3
`define P1IO_HI 4
`define P1IO_XCTL_T0EN 0
`define P1IO_XCTL_ROUTE 1
`define P1IO_XCTL_T0SRC 2
`define P1IO_XCTL_CMP 5
`define P1IO_ISL_BUZ 3
`define P1IO_ISL_CAPL 6
`define P1IO_ISL_CAPH 7
`define P1IO_I4_PSEL_HI 3
`define P1IO_I4_PSEL_LO 2
`define P1IO_I4FN_T1 2'h1
`define P1IO_I4FN_CAPL 2'h2
`define P1IO_I4FN_CAPH 2'h3
`endif

// file: logic/p1io_pkg.sv
package p1io_pkg;
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pu;
  } p1io_pins_t;
  typedef struct packed {
    logic t0_cnt;
    logic t0l_cap;
    logic t0h_cap;
    logic t1_cnt;
  } p1io_tmr_t;
endpackage

// file: sim/p1io_pin_model.sv
`timescale 1ns/100ps
// =============================================================
// board side of the eight port pins
module p1io_pin_model
  import p1io_pkg::*;
(
  input logic hclk,
  input p1io_pins_t pins,
  input logic [7:0] ext_val,
  input logic [7:0] ext_en,
  output logic [7:0] pin_in
);
  logic flt_q = 1'b0;

  // an undriven pin wanders, so a stale level never reads back as a match
  always @(posedge hclk) begin
    flt_q <= ~flt_q;
  end

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pins.oe[i]) begin
        pin_in[i] = pins.out[i];
      end else if (ext_en[i]) begin
        pin_in[i] = ext_val[i];
      end else if (pins.pu[i]) begin
        pin_in[i] = 1'b1;
      end else begin
        pin_in[i] = flt_q;
      end
    end
  end
endmodule // p1io_pin_model

// file: sim/test_p1io_port.sv
`timescale 1ns/100ps
`include "p1io_defines.svh"
module test_p1io_port
  import p1io_pkg::*;
;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hold = 1'b0;
  logic pwm = 1'b0, buz = 1'b0, cmp = 1'b0, sck = 1'b0, sdo = 1'b0, irq0 = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [7:0] ext_val = 8'h00, ext_en = 8'hF8;
  logic hreadyout, hresp, hold_release;
  logic [31:0] hrdata;
  logic [7:0] pin_in;
  logic [4:0] irq_req;
  p1io_pins_t pins;
  p1io_tmr_t tmr;
  int errors = 0, checks = 0, n_t0 = 0, n_t0l = 0, n_t0h = 0, n_t1 = 0;

  p1io_port i_p1io_port (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .pin_in(pin_in), .irq_zero_pin(irq0), .fast_pwm_second_output(pwm),
    .buzzer_in(buz), .comparator_in(cmp), .serial_clk_in(sck), .serial_data_in(sdo), .hold_mode(hold),
    .pins(pins), .tmr(tmr), .irq_req(irq_req), .hold_release(hold_release));
  p1io_pin_model i_p1io_pin_model (.hclk(hclk), .pins(pins), .ext_val(ext_val), .ext_en(ext_en),
    .pin_in(pin_in));

  initial begin
    forever #2.5 hclk = ~hclk;
  end

  // =============================================================
  // strobe counters
  always @(posedge hclk) begin
    n_t0 <= n_t0 + int'(tmr.t0_cnt === 1'b1);
    n_t0l <= n_t0l + int'(tmr.t0l_cap === 1'b1);
    n_t0h <= n_t0h + int'(tmr.t0h_cap === 1'b1);
    n_t1 <= n_t1 + int'(tmr.t1_cnt === 1'b1);
  end

  // =============================================================
  // shared tasks
  task automatic complete_run;
    if (errors == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic rdy;
    int n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      errors++;
      complete_run();
    end
  endtask

  // byte address is four times the register index
  task automatic bus(input logic [15:0] idx, input logic w, input logic [7:0] wd, output logic [7:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {14'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= {24'h0, wd};
    rdy();
    rd = hrdata[7:0];
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    logic [7:0] r;
    bus(idx, 1'b1, d, r);
  endtask

  task automatic rc(input logic [15:0] idx, input logic [7:0] e);
    logic [7:0] r;
    bus(idx, 1'b0, 8'h00, r);
    chk({24'h0, r}, {24'h0, e});
  endtask

  // pin edge needs two sync flops plus detection, six cycles is ample
  task automatic pin(input int b, input logic v);
    @(posedge hclk);
    ext_val[b] <= v;
    repeat (6) @(posedge hclk);
  endtask

  // =============================================================
  // scenarios
  task automatic t_reset;
    logic [15:0] idx [9] = '{`P1IO_IDX_RMW, `P1IO_IDX_DIR, `P1IO_IDX_FSEL, `P1IO_IDX_XCTL, `P1IO_IDX_EXT_IRQ_FOUR_FIVE_CTRL,
      `P1IO_IDX_EXT_IRQ_FOUR_FIVE_PIN_SELECT, `P1IO_IDX_EXT_IRQ_ZERO_ONE_CTRL, `P1IO_IDX_EXT_IRQ_TWO_THREE_CTRL, `P1IO_IDX_ISL};
    foreach (idx[i]) rc(idx[i], 8'h00);
    rc(16'hFE50, 8'h00);
    rc(`P1IO_IDX_TST, `P1IO_TST_RD);
    chk(hresp, 1'b0);
  endtask

  task automatic t_dir;
    ext_val <= 8'h50;
    wr(`P1IO_IDX_LATCH, 8'hA5);
    wr(`P1IO_IDX_DIR, 8'h0F);
    repeat (3) @(posedge hclk);
    chk(pins.oe, 8'h0F);
    chk(pins.out, 8'h05);
    chk(pins.pu, 8'hA0);
    rc(`P1IO_IDX_LATCH, 8'h55);
    rc(`P1IO_IDX_RMW, 8'hA5);
    ext_val <= 8'h00;
  endtask

  task automatic t_func;
    wr(`P1IO_IDX_DIR, 8'hFF);
    wr(`P1IO_IDX_LATCH, 8'h00);
    wr(`P1IO_IDX_FSEL, 8'hFF);
    wr(`P1IO_IDX_XCTL, 8'h02);
    pwm <= 1'b1;
    cmp <= 1'b1;
    sck <= 1'b1;
    repeat (3) @(posedge hclk);
    chk(pins.out, 8'hC4);
    sdo <= 1'b1;
    cmp <= 1'b0;
    repeat (3) @(posedge hclk);
    chk(pins.out, 8'h87);
    wr(`P1IO_IDX_XCTL, 8'h22);
    repeat (3) @(posedge hclk);
    chk(pins.out, 8'hC7);
    wr(`P1IO_IDX_XCTL, 8'h20);
    wr(`P1IO_IDX_ISL, 8'h08);
    buz <= 1'b1;
    pwm <= 1'b0;
    repeat (3) @(posedge hclk);
    chk(pins.out, 8'h87);
    wr(`P1IO_IDX_LATCH, 8'hFF);
    repeat (3) @(posedge hclk);
    chk(pins.out, 8'h7F);
    wr(`P1IO_IDX_ISL, 8'h00);
    repeat (3) @(posedge hclk);
    chk(pins.out, 8'hFF);
    wr(`P1IO_IDX_FSEL, 8'h00);
    wr(`P1IO_IDX_DIR, 8'h00);
    wr(`P1IO_IDX_LATCH, 8'h00);
    wr(`P1IO_IDX_XCTL, 8'h00);
  endtask

  task automatic t_irq1;
    logic [7:0] code [4] = '{8'h00, 8'h40, 8'h80, 8'hC0};
    int n;
    foreach (code[i]) begin
      wr(`P1IO_IDX_EXT_IRQ_ZERO_ONE_CTRL, code[i]);
      pin(7, ~code[i][7]);
      // second write clears whatever the start level left behind
      wr(`P1IO_IDX_EXT_IRQ_ZERO_ONE_CTRL, code[i]);
      n = n_t0h;
      pin(7, code[i][7]);
      chk(n_t0h - n > 1, code[i][6]);
      chk(n_t0h - n > 0, 1'b1);
      rc(`P1IO_IDX_EXT_IRQ_ZERO_ONE_CTRL, code[i] | 8'h20);
    end
    wr(`P1IO_IDX_EXT_IRQ_ZERO_ONE_CTRL, 8'hD0);
    repeat (3) @(posedge hclk);
    chk(hold_release, 1'b1);
    chk(irq_req, 5'h02);
    wr(`P1IO_IDX_EXT_IRQ_ZERO_ONE_CTRL, 8'hB0);
    repeat (3) @(posedge hclk);
    chk(hold_release, 1'b0);
    chk(irq_req, 5'h02);
    pin(7, 1'b0);
    rc(`P1IO_IDX_EXT_IRQ_ZERO_ONE_CTRL, 8'hB0);
    // irq zero pin held low in low-level mode: capture strobe repeats
    wr(`P1IO_IDX_EXT_IRQ_ZERO_ONE_CTRL, 8'h05);
    n = n_t0l;
    repeat (6) @(posedge hclk);
    chk(n_t0l - n > 1, 1'b1);
    chk(hold_release, 1'b1);
    chk(irq_req, 5'h01);
    wr(`P1IO_IDX_EXT_IRQ_ZERO_ONE_CTRL, 8'h00);
  endtask

  task automatic t_irq2;
    int n0;
    int nl;
    wr(`P1IO_IDX_XCTL, 8'h01);
    wr(`P1IO_IDX_ISL, 8'h40);
    wr(`P1IO_IDX_EXT_IRQ_TWO_THREE_CTRL, 8'h0D);
    n0 = n_t0;
    nl = n_t0l;
    pin(6, 1'b1);
    pin(6, 1'b0);
    chk(n_t0 - n0, 2);
    chk(n_t0l - nl, 2);
    rc(`P1IO_IDX_EXT_IRQ_TWO_THREE_CTRL, 8'h0F);
    chk(hold_release, 1'b1);
    wr(`P1IO_IDX_EXT_IRQ_TWO_THREE_CTRL, 8'h08);
    pin(6, 1'b1);
    // that rise set the flag before hold; clear it again
    wr(`P1IO_IDX_EXT_IRQ_TWO_THREE_CTRL, 8'h08);
    hold <= 1'b1;
    pin(6, 1'b0);
    pin(6, 1'b1);
    rc(`P1IO_IDX_EXT_IRQ_TWO_THREE_CTRL, 8'h08);
    wr(`P1IO_IDX_EXT_IRQ_TWO_THREE_CTRL, 8'h0C);
    pin(6, 1'b0);
    rc(`P1IO_IDX_EXT_IRQ_TWO_THREE_CTRL, 8'h0E);
    hold <= 1'b0;
    wr(`P1IO_IDX_EXT_IRQ_TWO_THREE_CTRL, 8'h00);
    wr(`P1IO_IDX_XCTL, 8'h00);
  endtask

  task automatic t_irq4;
    int n;
    wr(`P1IO_IDX_EXT_IRQ_FOUR_FIVE_PIN_SELECT, 8'h05);
    wr(`P1IO_IDX_EXT_IRQ_FOUR_FIVE_CTRL, 8'h09);
    n = n_t1;
    pin(4, 1'b1);
    chk(n_t1 - n, 1);
    rc(`P1IO_IDX_EXT_IRQ_FOUR_FIVE_CTRL, 8'h0B);
    chk(hold_release, 1'b1);
    // inhibited pin code: neither flag nor count
    wr(`P1IO_IDX_EXT_IRQ_FOUR_FIVE_PIN_SELECT, 8'h09);
    wr(`P1IO_IDX_EXT_IRQ_FOUR_FIVE_CTRL, 8'h0D);
    n = n_t1;
    pin(4, 1'b0);
    chk(n_t1 - n, 0);
    rc(`P1IO_IDX_EXT_IRQ_FOUR_FIVE_CTRL, 8'h0D);
    wr(`P1IO_IDX_EXT_IRQ_FOUR_FIVE_PIN_SELECT, 8'h01);
    wr(`P1IO_IDX_EXT_IRQ_FOUR_FIVE_CTRL, 8'h09);
    n = n_t1;
    pin(3, 1'b1);
    chk(n_t1 - n, 1);
  endtask

  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_dir();
    t_func();
    t_irq1();
    t_irq2();
    t_irq4();
    complete_run();
  end
endmodule // test_p1io_port
